// File: flash_host_pkg.sv
// Package for the flash status-polling host controller.
// Assumes a 20 MHz pclk and an 8-bit asynchronous parallel flash on the far side.
package flash_host_pkg;

	// ------------------------------------------------------------
	// APB register map (byte addresses)
	// ------------------------------------------------------------
	localparam logic [7:0] ctrl_off = 8'h00;
	localparam logic [7:0] addr_off = 8'h04;
	localparam logic [7:0] wdata_off = 8'h08;
	localparam logic [7:0] stat_off = 8'h0c;
	localparam logic [7:0] rdata_off = 8'h10;

	// Control register fields (write 1 to start or abort; self clearing)
	localparam int ctrl_read_bit = 0;
	localparam int ctrl_write_bit = 1;
	localparam int ctrl_poll_bit = 2;
	localparam int ctrl_abort_bit = 3;

	// Status register fields
	localparam int stat_busy_bit = 0;
	localparam int stat_done_bit = 1;
	localparam int stat_fail_bit = 2;
	localparam int stat_erase_tgl_bit = 3;

	// Device status byte layout (operation_status_byte)
	localparam int polarity_poll_pos = 7;
	localparam int toggle_bit_one_pos = 6;
	localparam int timeout_error_pos = 5;
	localparam int erase_toggle_pos = 2;

	// Reset command written to return the device to array reads
	localparam logic [15:0] reset_cmd_addr = 16'h0000;
	localparam logic [7:0] reset_cmd_data = 8'hf0;

	// ------------------------------------------------------------
	// Strobe timing
	// ------------------------------------------------------------
	localparam int clk_period_ns = 50;
	// Low phase must outlast the two-flop lag on returned data, or reads see stale lines
	localparam int strobe_low_ns = 150;
	localparam int strobe_high_ns = 50;
	localparam int noise_min_ns = 5;
	localparam int strobe_low_cyc = (strobe_low_ns + clk_period_ns - 1) / clk_period_ns;
	localparam int strobe_high_cyc = (strobe_high_ns + clk_period_ns - 1) / clk_period_ns;
	localparam logic [3:0] strobe_low_cnt = 4'(strobe_low_cyc);
	localparam logic [3:0] strobe_high_cnt = 4'(strobe_high_cyc);

	typedef enum logic [1:0] {cyc_idle, cyc_low, cyc_high} cyc_state_t;
	typedef enum logic [2:0] {
		op_idle, op_read, op_write, op_poll_a, op_poll_b, op_poll_c, op_reset
	} op_state_t;

endpackage

// File: flash_bus_if.sv
// Interface between the sequencer and the strobe engine.
// Assumes both ends run on pclk.
`timescale 1ns/1ps
interface flash_bus_if;
	logic req;
	logic wr;
	logic [15:0] addr;
	logic [7:0] wdata;
	logic ack;
	logic [7:0] rdata;
	modport master (output req, output wr, output addr, output wdata, input ack, input rdata);
	modport engine (input req, input wr, input addr, input wdata, output ack, output rdata);
endinterface

// File: flash_cycle_engine.sv
// Strobe engine: runs one read or write bus cycle on the flash pins.
// Assumes data_lines_i is already synchronised by the caller.
`timescale 1ns/1ps
module flash_cycle_engine
	import flash_host_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic clk_en,
	flash_bus_if.engine bus,
	input wire logic [7:0] data_lines_i,
	output logic [15:0] flash_addr,
	output logic [7:0] data_lines_o,
	output logic data_lines_oe,
	output logic chip_sel_n,
	output logic out_en_n,
	output logic write_en_n
);

	cyc_state_t st_q, st_d;
	logic [3:0] cnt_q, cnt_d;
	logic wr_q, wr_d;
	logic [15:0] addr_q, addr_d;
	logic [7:0] wd_q, wd_d;
	logic [7:0] rd_q, rd_d;
	logic ack_q, ack_d;

	// ------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------
	always_comb begin
		st_d = st_q;
		cnt_d = cnt_q;
		wr_d = wr_q;
		addr_d = addr_q;
		wd_d = wd_q;
		rd_d = rd_q;
		ack_d = 1'b0;
		case (st_q)
			cyc_idle: begin
				if (bus.req) begin
					st_d = cyc_low;
					cnt_d = strobe_low_cnt;
					wr_d = bus.wr;
					addr_d = bus.addr;
					wd_d = bus.wdata;
				end
			end
			cyc_low: begin
				// Strobes held many ns beyond the noise floor so every cycle counts
				if (cnt_q > 4'h1) begin
					cnt_d = cnt_q - 4'h1;
				end else begin
					// Sampling with out_en still low; the read ends on its rise
					rd_d = data_lines_i;
					st_d = cyc_high;
					cnt_d = strobe_high_cnt;
				end
			end
			cyc_high: begin
				if (cnt_q > 4'h1) begin
					cnt_d = cnt_q - 4'h1;
				end else begin
					st_d = cyc_idle;
					ack_d = 1'b1;
				end
			end
			default: st_d = cyc_idle;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_q <= cyc_idle;
			cnt_q <= 4'h0;
			wr_q <= 1'b0;
			addr_q <= 16'h0000;
			wd_q <= 8'h00;
			rd_q <= 8'h00;
			ack_q <= 1'b0;
		end else if (clk_en) begin
			st_q <= st_d;
			cnt_q <= cnt_d;
			wr_q <= wr_d;
			addr_q <= addr_d;
			wd_q <= wd_d;
			rd_q <= rd_d;
			ack_q <= ack_d;
		end
	end

	// Write uses chip select and write strobe low, never with out_en low
	assign chip_sel_n = (st_q != cyc_low);
	assign write_en_n = !((st_q == cyc_low) && wr_q);
	assign out_en_n = !((st_q == cyc_low) && !wr_q);
	assign data_lines_oe = (st_q != cyc_idle) && wr_q;
	assign data_lines_o = wd_q;
	assign flash_addr = addr_q;
	assign bus.ack = ack_q && clk_en;
	assign bus.rdata = rd_q;

endmodule

// File: flash_status_host.sv
// Host controller: APB slave that runs reads, writes and toggle polling
// on a parallel flash. Assumes the flash pins are asynchronous to pclk.
`timescale 1ns/1ps
// Contract
// - Host reads all lines twice, compares
// - Steady toggle means done; next read data
// - Toggling: check error bit, recheck if high
// - Still toggling after error: fail, reset command
// - Resumed polling restarts with a read pair
// - Write needs chip select and write strobe low
module flash_status_host
	import flash_host_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic clk_en,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output logic [15:0] flash_addr,
	input wire logic [7:0] data_lines_i,
	output logic [7:0] data_lines_o,
	output logic data_lines_oe,
	output logic chip_sel_n,
	output logic out_en_n,
	output logic write_en_n
);

	// ------------------------------------------------------------
	// Pin synchroniser
	// ------------------------------------------------------------
	logic [7:0] dl_meta_q, dl_sync_q;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			dl_meta_q <= 8'h00;
			dl_sync_q <= 8'h00;
		end else if (clk_en) begin
			dl_meta_q <= data_lines_i;
			dl_sync_q <= dl_meta_q;
		end
	end

	flash_bus_if bus ();

	flash_cycle_engine u_engine (
		.pclk(pclk),
		.presetn(presetn),
		.clk_en(clk_en),
		.bus(bus.engine),
		.data_lines_i(dl_sync_q),
		.flash_addr(flash_addr),
		.data_lines_o(data_lines_o),
		.data_lines_oe(data_lines_oe),
		.chip_sel_n(chip_sel_n),
		.out_en_n(out_en_n),
		.write_en_n(write_en_n)
	);

	function automatic logic toggled(input logic [7:0] a, input logic [7:0] b);
		return (a[toggle_bit_one_pos] != b[toggle_bit_one_pos]);
	endfunction

	function automatic logic erase_toggled(input logic [7:0] a, input logic [7:0] b);
		return (a[erase_toggle_pos] != b[erase_toggle_pos]);
	endfunction

	// ------------------------------------------------------------
	// Registers and sequencer
	// ------------------------------------------------------------
	op_state_t op_q, op_d;
	logic [15:0] addr_q, addr_d;
	logic [7:0] wdata_q, wdata_d;
	logic [7:0] rdata_q, rdata_d;
	logic [7:0] first_q, first_d;
	logic done_q, done_d;
	logic fail_q, fail_d;
	logic etgl_q, etgl_d;
	logic req_q, req_d;
	logic wr_q, wr_d;
	logic [15:0] baddr_q, baddr_d;
	logic [7:0] bwdata_q, bwdata_d;
	logic pend_q, pend_d;
	logic [31:0] prdata_q, prdata_d;

	logic bus_wr, rd_setup;
	logic go_read, go_write, go_poll, go_abort;
	logic busy;

	assign bus_wr = psel && penable && pwrite;
	assign rd_setup = psel && !penable && !pwrite;
	assign go_read = bus_wr && (paddr == ctrl_off) && pwdata[ctrl_read_bit];
	assign go_write = bus_wr && (paddr == ctrl_off) && pwdata[ctrl_write_bit];
	assign go_poll = bus_wr && (paddr == ctrl_off) && pwdata[ctrl_poll_bit];
	assign go_abort = bus_wr && (paddr == ctrl_off) && pwdata[ctrl_abort_bit];
	// A cycle left running by an abort keeps the block busy until its ack
	assign busy = (op_q != op_idle) || pend_q;

	always_comb begin
		op_d = op_q;
		addr_d = addr_q;
		wdata_d = wdata_q;
		rdata_d = rdata_q;
		first_d = first_q;
		done_d = done_q;
		fail_d = fail_q;
		etgl_d = etgl_q;
		req_d = 1'b0;
		wr_d = wr_q;
		baddr_d = baddr_q;
		bwdata_d = bwdata_q;
		if (bus_wr && (paddr == addr_off) && !busy) begin
			addr_d = pwdata[15:0];
		end
		if (bus_wr && (paddr == wdata_off) && !busy) begin
			wdata_d = pwdata[7:0];
		end
		case (op_q)
			op_idle: begin
				if ((go_read || go_write || go_poll) && !pend_q) begin
					done_d = 1'b0;
					fail_d = 1'b0;
					req_d = 1'b1;
					baddr_d = addr_q;
					bwdata_d = wdata_q;
					wr_d = go_write && !go_read;
					if (go_read) begin
						op_d = op_read;
					end else if (go_write) begin
						op_d = op_write;
					end else begin
						// Every poll starts afresh with a read pair
						op_d = op_poll_a;
						wr_d = 1'b0;
					end
				end
			end
			op_read, op_write, op_reset: begin
				if (bus.ack) begin
					if (op_q == op_read) begin
						rdata_d = bus.rdata;
					end
					done_d = 1'b1;
					op_d = op_idle;
				end
			end
			op_poll_a: begin
				if (bus.ack) begin
					first_d = bus.rdata;
					req_d = 1'b1;
					op_d = op_poll_b;
				end
			end
			op_poll_b, op_poll_c: begin
				if (bus.ack) begin
					rdata_d = bus.rdata;
					etgl_d = erase_toggled(first_q, bus.rdata);
					if (!toggled(first_q, bus.rdata)) begin
						// Steady toggle: operation over, array data next
						done_d = 1'b1;
						op_d = op_idle;
					end else if (op_q == op_poll_c) begin
						// Error bit seen and still toggling: failed
						fail_d = 1'b1;
						req_d = 1'b1;
						wr_d = 1'b1;
						baddr_d = reset_cmd_addr;
						bwdata_d = reset_cmd_data;
						op_d = op_reset;
					end else begin
						// Still toggling: recheck, escalate if error bit high
						first_d = bus.rdata;
						req_d = 1'b1;
						if (bus.rdata[timeout_error_pos]) begin
							op_d = op_poll_c;
						end
					end
				end else if (go_abort) begin
					// Host leaves polling; next poll restarts from a pair
					op_d = op_idle;
				end
			end
			default: op_d = op_idle;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			op_q <= op_idle;
			addr_q <= 16'h0000;
			wdata_q <= 8'h00;
			rdata_q <= 8'h00;
			first_q <= 8'h00;
			done_q <= 1'b0;
			fail_q <= 1'b0;
			etgl_q <= 1'b0;
			req_q <= 1'b0;
			wr_q <= 1'b0;
			baddr_q <= 16'h0000;
			bwdata_q <= 8'h00;
		end else if (clk_en) begin
			op_q <= op_d;
			addr_q <= addr_d;
			wdata_q <= wdata_d;
			rdata_q <= rdata_d;
			first_q <= first_d;
			done_q <= done_d;
			fail_q <= fail_d;
			etgl_q <= etgl_d;
			req_q <= req_d;
			wr_q <= wr_d;
			baddr_q <= baddr_d;
			bwdata_q <= bwdata_d;
		end
	end

	// ------------------------------------------------------------
	// Outstanding engine cycle
	// ------------------------------------------------------------
	// An abort leaves the engine running; its late ack must not pass
	// for the first read of the next poll, so starts wait for it.
	always_comb begin
		pend_d = pend_q;
		if (req_q) begin
			pend_d = 1'b1;
		end
		if (bus.ack) begin
			pend_d = 1'b0;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pend_q <= 1'b0;
		end else if (clk_en) begin
			pend_q <= pend_d;
		end
	end

	// A pending abort is dropped if an engine ack lands in the same cycle, whether or not the poll ends on it.
	assign bus.req = req_q;
	assign bus.wr = wr_q;
	assign bus.addr = baddr_q;
	assign bus.wdata = bwdata_q;

	// ------------------------------------------------------------
	// APB read mux
	// ------------------------------------------------------------
	// Read data is taken at the setup edge so it leaves a flop and
	// still stands through the zero-wait access phase.
	always_comb begin
		prdata_d = 32'h0000_0000;
		pslverr = 1'b0;
		case (paddr)
			ctrl_off: prdata_d = 32'h0000_0000;
			addr_off: prdata_d = {16'h0000, addr_q};
			wdata_off: prdata_d = {24'h00_0000, wdata_q};
			stat_off: begin
				prdata_d[stat_busy_bit] = busy;
				prdata_d[stat_done_bit] = done_q;
				prdata_d[stat_fail_bit] = fail_q;
				prdata_d[stat_erase_tgl_bit] = etgl_q;
			end
			rdata_off: prdata_d = {24'h00_0000, rdata_q};
			default: pslverr = psel && penable;
		endcase
		if (!rd_setup) begin
			prdata_d = 32'h0000_0000;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_q <= 32'h0000_0000;
		end else if (clk_en) begin
			prdata_q <= prdata_d;
		end
	end

	assign prdata = prdata_q;

	assign pready = 1'b1;

endmodule

// File: flash_status_host_asserts.sv
// Pin and APB checks for the flash host controller.
// Assumes it is bound to flash_status_host and sees only its ports.
`timescale 1ns/1ps
module flash_status_host_asserts (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic clk_en,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic [15:0] flash_addr,
	input wire logic [7:0] data_lines_i,
	input wire logic [7:0] data_lines_o,
	input wire logic data_lines_oe,
	input wire logic chip_sel_n,
	input wire logic out_en_n,
	input wire logic write_en_n
);
	// ------------------------------------------------------------
	// Properties
	// ------------------------------------------------------------
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	sequence s_low_run;
		!chip_sel_n [*2] ##1 chip_sel_n;
	endsequence
	sequence s_write_low;
		!write_en_n && data_lines_oe;
	endsequence
	property p_low_width;
		$fell(chip_sel_n) |=> s_low_run;
	endproperty
	a_low_width: assert property (p_low_width) else $error("strobe low not three cycles");
	property p_we_cs;
		!write_en_n |-> !chip_sel_n;
	endproperty
	a_we_cs: assert property (p_we_cs) else $error("write strobe without select");
	property p_not_all;
		!write_en_n |-> out_en_n;
	endproperty
	a_not_all: assert property (p_not_all) else $error("all three strobes low");
	property p_wr_drive;
		$fell(write_en_n) |-> s_write_low ##1 s_write_low;
	endproperty
	a_wr_drive: assert property (p_wr_drive) else $error("write data not driven");
	property p_read_cs;
		!out_en_n |-> !chip_sel_n && !data_lines_oe;
	endproperty
	a_read_cs: assert property (p_read_cs) else $error("read strobe misuse");
	property p_addr_hold;
		!chip_sel_n && !$fell(chip_sel_n) |-> $stable(flash_addr);
	endproperty
	a_addr_hold: assert property (p_addr_hold) else $error("address moved in cycle");
	property p_ready;
		psel && penable |-> pready;
	endproperty
	a_ready: assert property (p_ready) else $error("pready low in access");
	property p_err;
		psel && penable && (paddr > 8'h10) |-> pslverr;
	endproperty
	a_err: assert property (p_err) else $error("unmapped access not refused");
	property p_idle_rd;
		!(psel && penable) |-> prdata == 32'h0;
	endproperty
	a_idle_rd: assert property (p_idle_rd) else $error("prdata not zero outside access");
endmodule
bind flash_status_host flash_status_host_asserts u_chk (.pclk(pclk), .presetn(presetn),
	.clk_en(clk_en), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
	.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.flash_addr(flash_addr), .data_lines_i(data_lines_i), .data_lines_o(data_lines_o),
	.data_lines_oe(data_lines_oe), .chip_sel_n(chip_sel_n), .out_en_n(out_en_n),
	.write_en_n(write_en_n));

// File: flash_model.sv
// Behavioural flash device: status byte while busy, array data otherwise.
// Assumes the host raises chip select last with write data still driven.
`timescale 1ns/1ps
module flash_model
	import flash_host_pkg::*;
#(parameter int prog_reads = 3) (
	input wire logic chip_sel_n,
	input wire logic out_en_n,
	input wire logic write_en_n,
	input wire logic [15:0] flash_addr,
	input wire logic [7:0] data_lines_o,
	input wire logic data_lines_oe,
	output logic [7:0] data_lines_i
);
	logic [7:0] mem [16];
	logic [7:0] tgt = 8'h00;
	logic [7:0] last = 8'h00;
	logic [7:0] stat;
	logic busy = 0;
	logic fail = 0;
	logic err = 0;
	logic tgl = 0;
	int left = 0;
	logic lockout = 1'b1; // writes locked until the bench reports supply up
	logic [3:0] prot = 4'h0;
	logic ers = 0;
	logic sus = 0;
	logic [1:0] esec = 2'd0;
	logic etgl = 0;
	logic insec;
	logic [7:0] rd_val;
	task erase(input logic [1:0] s, input int n, input logic su);
		ers = 1; // status valid from the last command strobe on
		sus = su;
		esec = s;
		etgl = 0;
		err = 0;
		left = n;
	endtask
	task start(input int n, input logic f);
		busy = 1;
		fail = f;
		err = 0;
		left = n;
		tgt = 8'hff;
	endtask
	assign insec = ers && (flash_addr[15:14] == esec);
	assign stat = ers ? {sus, sus | tgl, err, 2'b00, insec & etgl, 2'b00}
		: {~tgt[7], tgl, err, 2'b00, tgl, 2'b00};
	assign rd_val = (busy || (ers && (insec || !sus))) ? stat : mem[flash_addr[3:0]];
	// Released lines show the inverse of the last byte, never a stale match
	assign data_lines_i = (!chip_sel_n && !out_en_n) ? rd_val : ~last;
	always @(posedge lockout) begin
		busy = 0;
		ers = 0;
	end
	always @(posedge chip_sel_n) begin
		if (data_lines_oe === 1'b1) begin
			if (flash_addr == reset_cmd_addr && data_lines_o == reset_cmd_data) begin
				busy = 0;
				err = 0;
			end else if (!busy && !lockout) begin
				if (!prot[flash_addr[15:14]]) mem[flash_addr[3:0]] = data_lines_o;
				tgt = mem[flash_addr[3:0]];
				busy = 1;
				fail = 0;
				left = prog_reads;
			end
		end else begin
			last = rd_val;
			if (insec) etgl = ~etgl;
			if (busy || (ers && !sus)) begin
				tgl = ~tgl;
				if (left > 0) left--;
				if (left == 0 && fail) err = 1;
				else if (left == 0) begin
					busy = 0;
					ers = 0;
				end
			end
		end
	end
endmodule

// File: tb_top.sv
// Self-checking bench for the flash host controller.
// Assumes the design answers APB with zero waits, as its note states.
`timescale 1ns/1ps
`define CHK(n, e, s) begin checks_done++; if ((s) !== (e)) begin fail_count++; \
	$display("wrong value %s exp %h got %h", n, e, s); end end
module tb_top;
	import flash_host_pkg::*;
	typedef struct {logic [31:0] e; logic [31:0] m;} note_t;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata, rd;
	logic pready, pslverr, data_lines_oe, chip_sel_n, out_en_n, write_en_n;
	logic [15:0] flash_addr;
	logic [7:0] data_lines_i, data_lines_o, wd;
	int fail_count = 0, checks_done = 0;
	note_t notes[$];
	note_t cur;
	always #25 pclk = ~pclk;
	flash_status_host dut (.pclk(pclk), .presetn(presetn), .clk_en(1'b1), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .flash_addr(flash_addr),
		.data_lines_i(data_lines_i), .data_lines_o(data_lines_o),
		.data_lines_oe(data_lines_oe), .chip_sel_n(chip_sel_n), .out_en_n(out_en_n),
		.write_en_n(write_en_n));
	flash_model fmodel (.chip_sel_n(chip_sel_n), .out_en_n(out_en_n),
		.write_en_n(write_en_n), .flash_addr(flash_addr), .data_lines_o(data_lines_o),
		.data_lines_oe(data_lines_oe), .data_lines_i(data_lines_i));
	task end_sim;
		if (fail_count == 0 && checks_done > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask
	// A zero mask marks a read whose value is only used to steer the bench
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d,
		input logic [31:0] e, input logic [31:0] m);
		int n;
		psel <= 1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		penable <= 0;
		@(posedge pclk);
		penable <= 1;
		if (!w) notes.push_back('{e, m});
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (n >= 50) begin
			fail_count++;
			end_sim();
		end
		rd = prdata;
		`CHK("pslverr", a > 8'h10, pslverr)
		psel <= 0;
		penable <= 0;
		@(posedge pclk);
	endtask
	task wait_idle;
		int k;
		k = 0;
		do begin
			apb(0, stat_off, 0, 0, 0);
			k++;
		end while (rd[stat_busy_bit] !== 1'b0 && k < 300);
		if (k >= 300) begin
			fail_count++;
			end_sim();
		end
	endtask
	task poll(input logic [31:0] e, input logic [31:0] m);
		apb(1, ctrl_off, 32'h1 << ctrl_poll_bit, 0, 0);
		wait_idle();
		apb(0, stat_off, 0, e, m);
	endtask
	task run(input int b);
		apb(1, ctrl_off, 32'h1 << b, 0, 0);
		wait_idle();
	endtask
	always @(posedge pclk) begin
		if (psel && penable && pready === 1'b1 && !pwrite && notes.size() > 0) begin
			cur = notes.pop_front();
			if (cur.m != 0) `CHK("prdata", cur.e, prdata & cur.m)
		end
	end
	initial begin
		#3000000;
		fail_count++;
		end_sim();
	end
	initial begin
		void'($urandom(30));
		repeat (6) @(posedge pclk);
		presetn <= 1;
		fmodel.lockout = 1'b0;
		@(posedge pclk);
		apb(0, stat_off, 0, 0, 32'hf);
		apb(0, 8'h14, 0, 0, 0);
		wd = 8'($urandom());
		apb(1, addr_off, 32'h5, 0, 0);
		apb(1, wdata_off, {24'h0, wd}, 0, 0);
		apb(1, ctrl_off, 32'h1 << ctrl_write_bit, 0, 0);
		wait_idle();
		poll(32'h2, 32'h7);
		apb(1, ctrl_off, 32'h1 << ctrl_read_bit, 0, 0);
		wait_idle();
		apb(0, rdata_off, 0, {24'h0, wd}, 32'hff);
		fmodel.start(4, 1);
		poll(32'h4, 32'h5);
		`CHK("device busy", 1'b0, fmodel.busy)
		fmodel.start(5, 0);
		poll(32'h2, 32'h7);
		fmodel.start(40, 0);
		apb(1, ctrl_off, 32'h1 << ctrl_poll_bit, 0, 0);
		repeat (12) @(posedge pclk);
		apb(1, ctrl_off, 32'h1 << ctrl_abort_bit, 0, 0);
		wait_idle();
		apb(0, stat_off, 0, 0, 32'h1);
		poll(32'h2, 32'h7);
		fmodel.prot[0] = 1'b1;
		apb(1, wdata_off, {24'h0, ~wd}, 0, 0);
		run(ctrl_write_bit);
		poll(32'h2, 32'h7);
		run(ctrl_read_bit);
		apb(0, rdata_off, 0, {24'h0, wd}, 32'hff);
		fmodel.prot[0] = 1'b0;
		fmodel.lockout = 1'b1;
		run(ctrl_write_bit);
		run(ctrl_read_bit);
		apb(0, rdata_off, 0, {24'h0, wd}, 32'hff);
		fmodel.lockout = 1'b0;
		apb(1, addr_off, 32'h4005, 0, 0);
		fmodel.erase(2'd1, 6, 1'b1);
		poll(32'ha, 32'hf);
		apb(1, addr_off, 32'h5, 0, 0);
		poll(32'h2, 32'hf);
		run(ctrl_read_bit);
		apb(0, rdata_off, 0, {24'h0, wd}, 32'hff);
		fmodel.ers = 1'b0;
		fmodel.erase(2'd1, 4, 1'b0);
		poll(32'h2, 32'h7);
		end_sim();
	end
endmodule
